//--- hdl/sram_port_host.sv
`include "sram_port_defs.svh"

module sram_port_host
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // User request port.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_byte_en,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory pins.
    output logic [ADDR_W-1:0] mem_addr,
    output logic select_low_active_n,
    output logic select_high_active,
    output logic write_strobe_n,
    output logic output_drive_n,
    output logic upper_byte_sel_n,
    output logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic [DATA_W-1:0] mem_data_oe
);

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam int RD_NS = (`ADDR_ACCESS_NS > `BYTE_SEL_ACCESS_NS) ? `ADDR_ACCESS_NS : `BYTE_SEL_ACCESS_NS;
    localparam int RD_CYC_RAW = `NS_TO_CYC(RD_NS);
    localparam int SUM_NS = `WRITE_DATA_SETUP_NS + `STROBE_TO_FLOAT_NS;
    localparam int WP_NS = (`WRITE_PULSE_NS > SUM_NS) ? `WRITE_PULSE_NS : SUM_NS;
    localparam int WP_MAX_NS = (WP_NS > `BYTE_SEL_TO_WRITE_END_NS) ? WP_NS : `BYTE_SEL_TO_WRITE_END_NS;
    localparam int WR_CYC_RAW = `NS_TO_CYC(WP_MAX_NS);
    // Sampling one cycle beyond the access time also covers the output drive access.
    localparam logic [3:0] RD_CYC = 4'(RD_CYC_RAW + 1);
    localparam logic [3:0] WR_CYC = 4'(WR_CYC_RAW);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    port_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [1:0] ben_r, ben_nxt;
    logic sel_r, sel_nxt, we_r, we_nxt, oe_r, oe_nxt, drive_r, drive_nxt;
    logic ready_r, ready_nxt, rsp_r, rsp_nxt;

    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] ben);
        lane_mask = {{(DATA_W/2){ben[1]}}, {(DATA_W/2){ben[0]}}};
    endfunction : lane_mask

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        ben_nxt = ben_r;
        sel_nxt = sel_r;
        we_nxt = we_r;
        oe_nxt = oe_r;
        drive_nxt = drive_r;
        ready_nxt = ready_r;
        rsp_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (req_valid && ready_r && req_byte_en != 2'b00) begin
                    // Address and byte lanes settle a cycle before select goes active.
                    addr_nxt = req_addr;
                    ben_nxt = req_byte_en;
                    wdata_nxt = req_wdata;
                    ready_nxt = 1'b0;
                    cnt_nxt = 4'h0;
                    state_nxt = req_write ? ST_WRITE : ST_READ;
                end else begin
                    // Ready comes back on the first edge after reset and stays up while nothing is taken.
                    ready_nxt = 1'b1;
                end
            end
            ST_READ: begin
                sel_nxt = 1'b1;
                oe_nxt = 1'b1;
                we_nxt = 1'b0;
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == RD_CYC) begin
                    rdata_nxt = mem_data_in & lane_mask(ben_r);
                    rsp_nxt = 1'b1;
                    state_nxt = ST_RD_DONE;
                end
            end
            ST_RD_DONE: begin
                // Staying selected with only the address changing keeps reads back to back.
                // A change of byte lanes ends the chain, since the lanes must not move within it.
                if (req_valid && !req_write && req_byte_en == ben_r) begin
                    addr_nxt = req_addr;
                    ben_nxt = req_byte_en;
                    cnt_nxt = 4'h0;
                    state_nxt = ST_READ;
                end else begin
                    sel_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // Select, strobe and data drive rise together, a cycle after the byte lanes; the strobe alone ends the window.
                sel_nxt = 1'b1;
                we_nxt = 1'b1;
                oe_nxt = 1'b0;
                drive_nxt = 1'b1;
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == WR_CYC) begin
                    we_nxt = 1'b0;
                    state_nxt = ST_WR_END;
                end
            end
            ST_WR_END: begin
                // Data and selects stand one cycle past the strobe rising edge.
                sel_nxt = 1'b0;
                drive_nxt = 1'b0;
                ready_nxt = 1'b1;
                rsp_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            ben_r <= 2'b00;
            sel_r <= 1'b0;
            we_r <= 1'b0;
            oe_r <= 1'b0;
            drive_r <= 1'b0;
            ready_r <= 1'b0;
            rsp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            ben_r <= ben_nxt;
            sel_r <= sel_nxt;
            we_r <= we_nxt;
            oe_r <= oe_nxt;
            drive_r <= drive_nxt;
            ready_r <= ready_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    // Every pin comes straight from a flop, so no decode glitch can reach the memory.
    logic sel_low_n_r, sel_low_n_nxt, sel_high_r, sel_high_nxt;
    logic strobe_n_r, strobe_n_nxt, drive_n_r, drive_n_nxt;
    logic upper_n_r, upper_n_nxt, lower_n_r, lower_n_nxt;
    logic [DATA_W-1:0] data_oe_r, data_oe_nxt;

    // Byte lanes stay asserted between transfers; the chip selects alone put the device in standby.
    always_comb begin
        sel_low_n_nxt = ~sel_nxt;
        sel_high_nxt = sel_nxt;
        strobe_n_nxt = ~we_nxt;
        drive_n_nxt = ~oe_nxt;
        upper_n_nxt = ~ben_nxt[1];
        lower_n_nxt = ~ben_nxt[0];
        data_oe_nxt = drive_nxt ? lane_mask(ben_nxt) : '0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sel_low_n_r <= 1'b1;
            sel_high_r <= 1'b0;
            strobe_n_r <= 1'b1;
            drive_n_r <= 1'b1;
            upper_n_r <= 1'b1;
            lower_n_r <= 1'b1;
            data_oe_r <= '0;
        end else begin
            sel_low_n_r <= sel_low_n_nxt;
            sel_high_r <= sel_high_nxt;
            strobe_n_r <= strobe_n_nxt;
            drive_n_r <= drive_n_nxt;
            upper_n_r <= upper_n_nxt;
            lower_n_r <= lower_n_nxt;
            data_oe_r <= data_oe_nxt;
        end
    end

    assign mem_addr = addr_r;
    assign select_low_active_n = sel_low_n_r;
    assign select_high_active = sel_high_r;
    assign write_strobe_n = strobe_n_r;
    assign output_drive_n = drive_n_r;
    assign upper_byte_sel_n = upper_n_r;
    assign lower_byte_sel_n = lower_n_r;
    assign mem_data_out = wdata_r;
    assign mem_data_oe = data_oe_r;
    assign req_ready = ready_r;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;

endmodule : sram_port_host

//--- hdl/sram_port_defs.svh
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// Clock period in picoseconds (20 MHz).
`define CLK_PERIOD_PS 50000
// Least times in nanoseconds, fast grade.
`define READ_CYCLE_NS 45
`define ADDR_ACCESS_NS 45
`define OUT_DRIVE_ACCESS_NS 22
`define BYTE_SEL_ACCESS_NS 45
`define WRITE_CYCLE_NS 45
`define WRITE_PULSE_NS 35
`define BYTE_SEL_TO_WRITE_END_NS 35
`define WRITE_DATA_SETUP_NS 25
`define STROBE_TO_FLOAT_NS 18
// Least times round up to whole cycles.
`define NS_TO_CYC(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

//--- hdl/sram_port_pkg.sv
package sram_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_RD_DONE = 3'b011,
        ST_WRITE = 3'b010,
        ST_WR_END = 3'b110
    } port_state_e;

endpackage : sram_port_pkg

//--- dv/sram_port_chk.sv
module sram_port_chk #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Memory pins.
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic [DATA_W-1:0] mem_data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic sel = !select_low_active_n && select_high_active;
    wire logic [1:0] bsel_n = {upper_byte_sel_n, lower_byte_sel_n};
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // One low cycle of 50 ns already covers the data setup plus the strobe-to-float delay.
    sequence wr_pulse_s;
        !write_strobe_n ##1 write_strobe_n;
    endsequence
    sequence wr_release_s;
        sel ##1 !sel;
    endsequence
    wr_window_a: assert property (!write_strobe_n |-> sel && bsel_n != 2'b11 && output_drive_n)
        else $error("strobe low outside full select overlap");
    wr_end_a: assert property ($rose(write_strobe_n) |-> wr_release_s)
        else $error("write not ended by the strobe");
    wr_data_a: assert property (wr_pulse_s |-> $stable(mem_data_out) && mem_data_oe != '0)
        else $error("write data moved at the closing edge");
    rd_strobe_a: assert property (!output_drive_n |-> write_strobe_n)
        else $error("strobe low during a read");
    rd_steady_a: assert property (!output_drive_n && $past(!output_drive_n) |-> $stable({sel, bsel_n}))
        else $error("controls moved within a read");
    rd_addr_a: assert property ($rose(sel) |-> $stable(mem_addr))
        else $error("address moved as select rose");
    wr_lanes_a: assert property ($fell(write_strobe_n) |-> $stable(bsel_n) [*2])
        else $error("byte selects moved before write end");
    wr_pulse_a: assert property ($fell(write_strobe_n) |-> wr_pulse_s)
        else $error("write pulse length wrong");
    drive_fight_a: assert property (mem_data_oe != '0 |-> output_drive_n)
        else $error("host drove data while memory outputs were enabled");
endmodule : sram_port_chk

bind sram_port_host sram_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.*);

//--- dv/sram_model.sv
module sram_model #(
    parameter int ACCESS_NS = 45,
    parameter int OE_NS = 22
) (
    // Memory pins.
    input wire logic [17:0] mem_addr,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [15:0] mem_data_out,
    output logic [15:0] mem_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:262143];
    logic [15:0] word;
    logic [15:0] rd_late;
    logic [1:0] pick_late;
    logic oe_late;
    wire logic sel = !select_low_active_n && select_high_active;
    wire logic [1:0] pick = {2{sel && write_strobe_n}} & ~{upper_byte_sel_n, lower_byte_sel_n};
    wire logic wr = (sel && !write_strobe_n && !(upper_byte_sel_n && lower_byte_sel_n)) === 1'b1;
    // Unwritten words read as all ones, so a stray read shows a known wrong value.
    initial begin
        for (int i = 0; i < 262144; i++) begin
            mem[i] = 16'hffff;
        end
    end
    always_comb word = mem[mem_addr];
    // Inertial delays: data only shows once its cause has been steady for the access time.
    assign #(ACCESS_NS) rd_late = word;
    assign #(ACCESS_NS) pick_late = pick;
    assign #(OE_NS) oe_late = !output_drive_n;
    wire logic [1:0] drv = pick & pick_late & {2{oe_late && !output_drive_n}};
    assign mem_data_in = {drv[1] ? rd_late[15:8] : ~rd_late[15:8], drv[0] ? rd_late[7:0] : ~rd_late[7:0]};
    always @(negedge wr) begin
        mem[mem_addr] = {upper_byte_sel_n ? word[15:8] : mem_data_out[15:8],
                         lower_byte_sel_n ? word[7:0] : mem_data_out[7:0]};
    end
endmodule : sram_model

//--- dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset, req_valid, req_write, req_ready, rsp_valid, write_strobe_n, output_drive_n;
    logic select_low_active_n, select_high_active, upper_byte_sel_n, lower_byte_sel_n;
    logic [17:0] req_addr, mem_addr;
    logic [15:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out, mem_data_oe;
    logic [1:0] req_byte_en;
    int mismatches, cmp_count;
    sram_port_host u_dut (.*);
    sram_model u_mem (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task timed_out;
        mismatches++;
        $display("timeout waiting on the port");
        end_sim();
    endtask : timed_out
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        if (req_ready !== 1'b1) begin
            timed_out();
        end
    endtask : wait_ready
    task wait_rsp;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 40);
        if (rsp_valid !== 1'b1) begin
            timed_out();
        end
    endtask : wait_rsp
    task xfer(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk);
        {req_valid, req_write, req_addr, req_wdata, req_byte_en} <= {1'b1, w, a, d, be};
        wait_ready();
        // The request stands through the edge that finds ready high.
        @(posedge clk);
        req_valid <= 1'b0;
        wait_rsp();
        @(posedge clk);
    endtask : xfer
    task rd(input logic [17:0] a, input logic [1:0] be, input logic [15:0] exp);
        xfer(1'b0, a, 16'h0000, be);
        chk("read data", exp, rsp_rdata);
    endtask : rd
    task t_word;
        xfer(1'b1, 18'h00010, 16'ha5c3, 2'b11);
        rd(18'h00010, 2'b11, 16'ha5c3);
        $display("word test done");
    endtask : t_word
    task t_lanes;
        xfer(1'b1, 18'h3ffff, 16'h1234, 2'b11);
        xfer(1'b1, 18'h3ffff, 16'hbeef, 2'b10);
        rd(18'h3ffff, 2'b11, 16'hbe34);
        rd(18'h3ffff, 2'b01, 16'h0034);
        rd(18'h3ffff, 2'b10, 16'hbe00);
        $display("lane test done");
    endtask : t_lanes
    task t_refuse;
        @(posedge clk);
        {req_valid, req_write, req_addr, req_wdata, req_byte_en} <= {1'b1, 1'b1, 18'h00010, 16'h0000, 2'b00};
        repeat (10) begin
            @(negedge clk);
            chk("ready response strobe", 16'h0005, {13'h0000, req_ready, rsp_valid, write_strobe_n});
        end
        @(posedge clk);
        req_valid <= 1'b0;
        rd(18'h00010, 2'b11, 16'ha5c3);
        $display("refusal test done");
    endtask : t_refuse
    task t_chain;
        int n;
        @(posedge clk);
        {req_valid, req_write, req_addr, req_byte_en} <= {1'b1, 1'b0, 18'h00010, 2'b11};
        wait_ready();
        // The second read is held up from the first take, so it is found in the cycle of the answer.
        @(posedge clk);
        req_addr <= 18'h3ffff;
        wait_rsp();
        chk("first chained read", 16'ha5c3, rsp_rdata);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            chk("pins held in chain", 16'h0004, {12'h000, req_ready, select_high_active, select_low_active_n, output_drive_n});
        end while (rsp_valid !== 1'b1 && n < 40);
        if (rsp_valid !== 1'b1) begin
            timed_out();
        end
        chk("second chained read", 16'hbe34, rsp_rdata);
        @(posedge clk);
        $display("chain test done");
    endtask : t_chain
    initial begin
        {reset, req_valid, req_write, req_addr, req_wdata, req_byte_en} = {1'b1, 38'h0};
        mismatches = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_word();
        t_lanes();
        t_refuse();
        t_chain();
        end_sim();
    end
endmodule : tb_top
